// ---- design/dfl_fault_latch.sv ----
// Fault supervision: trip classification, alarm latch, dip ride-through
// Operation
// (RL1) Over-current trips get separate codes for accel, decel, steady phases.
// (RL2) Protective trips stop output, let motor coast, assert alarm contact.
// (RL3) Alarm stays latched after a trip until a reset command arrives.
// (RL4) Dips under 15 ms ride through; longer dips stop with undervoltage code.
// (RL5) With restart mode selected, operation resumes when power returns.
// (RL6) Over-voltage indication trips with the overvoltage code.
// (RL7) Heatsink overheat indication trips with internal overheat code.
// (RL8) External thermal input going on to off trips with thermal code.
// (RL9) Electronic motor overload trips with its own code.
// (RL10) Incompatible function settings show the setting error code.
// (RL11) Continuous panel communication failure shows the comm error code.
// (RL12) Processor malfunction shows the processor error code.
// (RL13) Link wiring mismatch during link operation shows link error code.
// (RL14) Operator clears a stop with panel reset key or reset terminal.
// (RL15) Three most recent trips are kept in history.
// (RL16) Shift key steps history view from newest to third previous.
// (RL17) Each trip captures frequency, voltage, current and temperature.
// (RL18) Latched alarm need not survive loss of control supply.
// (RL19) A new trip shifts history back and drops the oldest entry.
// (RL20) Reset clears the alarm latch and leaves history untouched.
`timescale 1ns/10ps
module dfl_fault_latch #(
  parameter int unsigned DIP_LIMIT_CYC = dfl_pkg::DIP_LIMIT_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire dfl_pkg::dfl_det_type det_i,
  input wire dfl_pkg::dfl_phase_type phase_i,
  input wire dfl_pkg::dfl_cond_type cond_i,
  input wire logic external_thermal_input_i,
  input wire logic fault_reset_input_i,
  input wire logic reset_key_i,
  input wire logic shift_key_i,
  input wire logic restart_mode_i,
  input wire logic link_mode_i,
  output logic drive_enable_o,
  output logic coast_o,
  output logic alarm_o,
  output dfl_pkg::dfl_code_type code_o,
  output dfl_pkg::dfl_entry_type hist_view_o,
  output logic [1:0] hist_idx_o
);
  typedef enum logic [1:0] {
    DFL_ST_RUN = 2'b00,
    DFL_ST_DIP = 2'b01,
    DFL_ST_UV_STOP = 2'b11,
    DFL_ST_TRIP = 2'b10
  } dfl_state_type;

  localparam int unsigned CNT_W = $clog2(DIP_LIMIT_CYC + 1);

  dfl_state_type state_reg;
  dfl_state_type state_next;
  logic [CNT_W-1:0] dip_cnt_reg;
  logic [2:0] thr_sync_reg;
  logic [2:0] rst_sync_reg;
  logic [2:0] key_sync_reg;
  logic [2:0] shift_sync_reg;
  dfl_pkg::dfl_det_type det_s1_reg;
  dfl_pkg::dfl_det_type det_s2_reg;
  logic [1:0] restart_sync_reg;
  logic [1:0] link_sync_reg;
  logic thr_fall;
  logic reset_cmd;
  logic shift_press;
  logic trip_now;
  logic dip_expired;
  dfl_pkg::dfl_code_type trip_code;
  logic alarm_reg;
  dfl_pkg::dfl_code_type code_reg;
  logic push;
  logic prot_cause;
  logic err_cause;

  // Pins from outside the clock domain, except phase_i and cond_i, pass two flops before any logic
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      thr_sync_reg <= 3'h7; // Thermal contact idles closed (ON)
      rst_sync_reg <= 3'h0;
      key_sync_reg <= 3'h0;
      shift_sync_reg <= 3'h0;
      det_s1_reg <= '0;
      det_s2_reg <= '0;
      restart_sync_reg <= 2'h0;
      link_sync_reg <= 2'h0;
    end else begin
      thr_sync_reg <= {thr_sync_reg[1:0], external_thermal_input_i};
      rst_sync_reg <= {rst_sync_reg[1:0], fault_reset_input_i};
      key_sync_reg <= {key_sync_reg[1:0], reset_key_i};
      shift_sync_reg <= {shift_sync_reg[1:0], shift_key_i};
      det_s1_reg <= det_i;
      det_s2_reg <= det_s1_reg;
      restart_sync_reg <= {restart_sync_reg[0], restart_mode_i};
      link_sync_reg <= {link_sync_reg[0], link_mode_i};
    end
  end

  // Edge detectors look only at the second and third stages
  // (RL8) on-to-off thermal edge
  assign thr_fall = thr_sync_reg[2] && !thr_sync_reg[1];
  // (RL14) key or terminal resets
  assign reset_cmd = (key_sync_reg[1] && !key_sync_reg[2])
    || (rst_sync_reg[1] && !rst_sync_reg[2]);
  assign shift_press = shift_sync_reg[1] && !shift_sync_reg[2];

  // Trip classification; the first listed cause wins when several coincide
  always_comb begin
    trip_code = dfl_pkg::DFL_NONE;
    if (det_s2_reg.overcurrent) begin
      // (RL1) phase-specific codes
      case (phase_i)
        dfl_pkg::DFL_PH_ACCEL: trip_code = dfl_pkg::DFL_OC_ACCEL;
        dfl_pkg::DFL_PH_DECEL: trip_code = dfl_pkg::DFL_OC_DECEL;
        default: trip_code = dfl_pkg::DFL_OC_STEADY;
      endcase
    end else if (det_s2_reg.overvoltage) begin
      // (RL6) overvoltage trip
      trip_code = dfl_pkg::DFL_OVERVOLT;
    end else if (det_s2_reg.heatsink_hot) begin
      // (RL7) heatsink overheat trip
      trip_code = dfl_pkg::DFL_INT_OVERHEAT;
    end else if (thr_fall) begin
      // (RL8) external thermal trip
      trip_code = dfl_pkg::DFL_EXT_THERMAL;
    end else if (det_s2_reg.motor_overload) begin
      // (RL9) electronic overload trip
      trip_code = dfl_pkg::DFL_MOTOR_OVERLOAD;
    end else if (det_s2_reg.processor_fault) begin
      // (RL12) processor error
      trip_code = dfl_pkg::DFL_PROCESSOR_ERR;
    end else if (det_s2_reg.setting_error) begin
      // (RL10) setting error
      trip_code = dfl_pkg::DFL_SETTING_ERR;
    end else if (det_s2_reg.panel_comm_bad) begin
      // (RL11) panel comm error
      trip_code = dfl_pkg::DFL_PANEL_COMM_ERR;
    end else if (det_s2_reg.link_mismatch && link_sync_reg[1]) begin
      // (RL13) link mismatch in link mode
      trip_code = dfl_pkg::DFL_LINK_MISMATCH;
    end
  end

  assign trip_now = (trip_code != dfl_pkg::DFL_NONE);
  assign dip_expired = (dip_cnt_reg >= CNT_W'(DIP_LIMIT_CYC));

  // Dip timer counts while undervoltage persists in the ride-through state
  // (RL4) 15 ms ride-through window
  always_ff @(posedge clk_i) begin
    if (reset_i || state_reg != DFL_ST_DIP) begin
      dip_cnt_reg <= '0;
    end else if (!dip_expired) begin
      dip_cnt_reg <= dip_cnt_reg + CNT_W'(1);
    end
  end

  // Supervisor state; a trip outranks any undervoltage handling
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DFL_ST_RUN: begin
        if (trip_now) begin
          state_next = DFL_ST_TRIP;
        end else if (det_s2_reg.undervoltage) begin
          state_next = DFL_ST_DIP;
        end
      end
      DFL_ST_DIP: begin
        if (trip_now) begin
          state_next = DFL_ST_TRIP;
        end else if (!det_s2_reg.undervoltage) begin
          state_next = DFL_ST_RUN;
        end else if (dip_expired) begin
          state_next = DFL_ST_UV_STOP;
        end
      end
      DFL_ST_UV_STOP: begin
        if (trip_now) begin
          state_next = DFL_ST_TRIP;
        end else if (!det_s2_reg.undervoltage
            && (restart_sync_reg[1] || reset_cmd)) begin
          // (RL5) auto restart on recovery
          state_next = DFL_ST_RUN;
        end
      end
      DFL_ST_TRIP: begin
        // (RL20) reset leaves latch state
        if (reset_cmd && !trip_now) begin
          state_next = DFL_ST_RUN;
        end
      end
      default: state_next = DFL_ST_RUN;
    endcase
  end

  // Plain flops: control supply loss clears everything, by design
  // (RL18) no retention needed
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= DFL_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Alarm latch; a trip in the reset cycle wins over the clear
  // (RL3) held until reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      alarm_reg <= 1'b0;
    end else if (trip_now) begin
      alarm_reg <= 1'b1;
    end else if (reset_cmd && state_reg == DFL_ST_TRIP) begin
      alarm_reg <= 1'b0;
    end
  end

  // Displayed code: trip code held, undervoltage shown without alarm
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      code_reg <= dfl_pkg::DFL_NONE;
    end else if (state_reg != DFL_ST_TRIP && trip_now) begin
      code_reg <= trip_code;
    end else if (state_reg == DFL_ST_DIP && dip_expired
        && det_s2_reg.undervoltage) begin
      // (RL4) undervoltage code, no alarm
      code_reg <= dfl_pkg::DFL_UNDERVOLT;
    end else if (state_next == DFL_ST_RUN && state_reg != DFL_ST_RUN) begin
      code_reg <= dfl_pkg::DFL_NONE;
    end
  end

  // History logs each new trip, protective or error, once, with conditions
  // (RL17) capture operating conditions
  assign push = trip_now && state_reg != DFL_ST_TRIP;

  dfl_history #(
    .DEPTH(dfl_pkg::HIST_DEPTH)
  ) u_history (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .push_i(push),
    .entry_i({trip_code, cond_i}),
    .step_i(shift_press),
    .view_o(hist_view_o),
    .view_idx_o(hist_idx_o)
  );

  // (RL2) stop output, coast, alarm
  assign drive_enable_o = (state_reg == DFL_ST_RUN)
    || (state_reg == DFL_ST_DIP);
  assign coast_o = !drive_enable_o;
  assign alarm_o = alarm_reg;
  assign code_o = code_reg;

  // Cause groups used only by the code checks, to express priority
  assign prot_cause = det_s2_reg.overcurrent || det_s2_reg.overvoltage
    || det_s2_reg.heatsink_hot || thr_fall || det_s2_reg.motor_overload;
  assign err_cause = det_s2_reg.processor_fault || det_s2_reg.setting_error
    || det_s2_reg.panel_comm_bad;

  a_trip_stops: assert property (@(posedge clk_i) disable iff (reset_i)
    trip_now |=> !drive_enable_o && alarm_o) // RL2
    else $error("trip did not stop drive and raise alarm");
  a_alarm_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    (alarm_o && !reset_cmd) |=> alarm_o) // RL3
    else $error("alarm dropped without reset");
  a_reset_clears: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_reg == DFL_ST_TRIP && reset_cmd && !trip_now) |=> !alarm_o)
    // RL20
    else $error("reset did not clear alarm");
  a_dip_ride: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_reg == DFL_ST_DIP && !dip_expired && !trip_now)
    |=> drive_enable_o) // RL4
    else $error("short dip stopped drive");
  a_uv_noalarm: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_reg == DFL_ST_DIP && dip_expired && det_s2_reg.undervoltage
    && !trip_now && !alarm_o) |=> code_o == dfl_pkg::DFL_UNDERVOLT
    && !alarm_o) // RL4
    else $error("long dip not shown as undervoltage");
  a_restart_auto: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_reg == DFL_ST_UV_STOP && !det_s2_reg.undervoltage
    && restart_sync_reg[1] && !trip_now) |=> drive_enable_o) // RL5
    else $error("no automatic restart");
  a_oc_accel: assert property (@(posedge clk_i) disable iff (reset_i)
    (push && det_s2_reg.overcurrent && phase_i == dfl_pkg::DFL_PH_ACCEL)
    |=> code_o == dfl_pkg::DFL_OC_ACCEL) // RL1
    else $error("accel overcurrent code wrong");
  a_thermal_edge: assert property (@(posedge clk_i) disable iff (reset_i)
    (push && thr_fall && trip_code == dfl_pkg::DFL_EXT_THERMAL)
    |=> code_o == dfl_pkg::DFL_EXT_THERMAL && alarm_o) // RL8
    else $error("external thermal trip wrong");
  a_oc_decel: assert property (@(posedge clk_i) disable iff (reset_i)
    (push && det_s2_reg.overcurrent && phase_i == dfl_pkg::DFL_PH_DECEL)
    |=> code_o == dfl_pkg::DFL_OC_DECEL) // RL1
    else $error("decel overcurrent code wrong");
  a_oc_steady: assert property (@(posedge clk_i) disable iff (reset_i)
    (push && det_s2_reg.overcurrent && phase_i == dfl_pkg::DFL_PH_STEADY)
    |=> code_o == dfl_pkg::DFL_OC_STEADY) // RL1
    else $error("steady overcurrent code wrong");
  // Each single cause shows its own code once higher causes are absent
  a_ov_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (push && det_s2_reg.overvoltage && !det_s2_reg.overcurrent)
    |=> code_o == dfl_pkg::DFL_OVERVOLT && alarm_o) // RL6
    else $error("overvoltage trip code wrong");
  a_heat_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (push && det_s2_reg.heatsink_hot && !det_s2_reg.overcurrent
    && !det_s2_reg.overvoltage)
    |=> code_o == dfl_pkg::DFL_INT_OVERHEAT && alarm_o) // RL7
    else $error("overheat trip code wrong");
  a_overload_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (push && det_s2_reg.motor_overload && !det_s2_reg.overcurrent
    && !det_s2_reg.overvoltage && !det_s2_reg.heatsink_hot && !thr_fall)
    |=> code_o == dfl_pkg::DFL_MOTOR_OVERLOAD && alarm_o) // RL9
    else $error("overload trip code wrong");
  a_cpu_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (push && det_s2_reg.processor_fault && !prot_cause)
    |=> code_o == dfl_pkg::DFL_PROCESSOR_ERR) // RL12
    else $error("processor error code wrong");
  a_setting_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (push && det_s2_reg.setting_error && !prot_cause
    && !det_s2_reg.processor_fault)
    |=> code_o == dfl_pkg::DFL_SETTING_ERR) // RL10
    else $error("setting error code wrong");
  a_comm_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (push && det_s2_reg.panel_comm_bad && !prot_cause
    && !det_s2_reg.processor_fault && !det_s2_reg.setting_error)
    |=> code_o == dfl_pkg::DFL_PANEL_COMM_ERR) // RL11
    else $error("panel comm error code wrong");
  a_link_code: assert property (@(posedge clk_i) disable iff (reset_i)
    (push && det_s2_reg.link_mismatch && link_sync_reg[1]
    && !prot_cause && !err_cause)
    |=> code_o == dfl_pkg::DFL_LINK_MISMATCH) // RL13
    else $error("link error code wrong");
  // Outside link operation a wiring mismatch means nothing
  a_link_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    (det_s2_reg.link_mismatch && !link_sync_reg[1]
    && !prot_cause && !err_cause) |-> !trip_now) // RL13
    else $error("link error raised outside link operation");
  a_reset_resume: assert property (@(posedge clk_i) disable iff (reset_i)
    (state_reg == DFL_ST_TRIP && reset_cmd && !trip_now)
    |=> drive_enable_o && code_o == dfl_pkg::DFL_NONE) // RL20
    else $error("reset did not resume drive");

  c_trip_reset: cover property (@(posedge clk_i) disable iff (reset_i)
    state_reg == DFL_ST_TRIP ##[1:50] state_reg == DFL_ST_RUN);
  c_dip_ride: cover property (@(posedge clk_i) disable iff (reset_i)
    state_reg == DFL_ST_DIP ##1 state_reg == DFL_ST_RUN);
  c_uv_stop: cover property (@(posedge clk_i) disable iff (reset_i)
    state_reg == DFL_ST_UV_STOP);
  c_thermal_trip: cover property (@(posedge clk_i) disable iff (reset_i)
    push && thr_fall);
  c_link_trip: cover property (@(posedge clk_i) disable iff (reset_i)
    push && trip_code == dfl_pkg::DFL_LINK_MISMATCH);
endmodule

// ---- design/dfl_pkg.sv ----
// Package: trip codes, timing counts and carrier structs for the fault latch
package dfl_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned DIP_LIMIT_US = 15_000;
  // Longest tolerated dip rounds down to whole cycles
  localparam int unsigned DIP_LIMIT_CYC = (CLK_HZ / 1_000_000) * DIP_LIMIT_US;
  localparam int unsigned HIST_DEPTH = 3;
  localparam int unsigned MON_W = 16;

  typedef enum logic [3:0] {
    DFL_NONE = 4'h0,
    DFL_OC_ACCEL = 4'h1,
    DFL_OC_DECEL = 4'h2,
    DFL_OC_STEADY = 4'h3,
    DFL_UNDERVOLT = 4'h4,
    DFL_OVERVOLT = 4'h5,
    DFL_INT_OVERHEAT = 4'h6,
    DFL_EXT_THERMAL = 4'h7,
    DFL_MOTOR_OVERLOAD = 4'h8,
    DFL_SETTING_ERR = 4'h9,
    DFL_PANEL_COMM_ERR = 4'hA,
    DFL_PROCESSOR_ERR = 4'hB,
    DFL_LINK_MISMATCH = 4'hC
  } dfl_code_type;

  typedef enum logic [1:0] {
    DFL_PH_STEADY = 2'h0,
    DFL_PH_ACCEL = 2'h1,
    DFL_PH_DECEL = 2'h2
  } dfl_phase_type;

  // Operating conditions captured alongside a trip code
  typedef struct packed {
    logic [MON_W-1:0] freq;
    logic [MON_W-1:0] volt;
    logic [MON_W-1:0] curr;
    logic [MON_W-1:0] temp;
  } dfl_cond_type;

  typedef struct packed {
    dfl_code_type code;
    dfl_cond_type cond;
  } dfl_entry_type;

  // Fault detector indications from the power stage, setting check, panel link, processor and link wiring
  typedef struct packed {
    logic overcurrent;
    logic overvoltage;
    logic heatsink_hot;
    logic motor_overload;
    logic undervoltage;
    logic setting_error;
    logic panel_comm_bad;
    logic processor_fault;
    logic link_mismatch;
  } dfl_det_type;
endpackage

// ---- design/dfl_history.sv ----
// Three-deep trip history shift register with shift-key view selection
`timescale 1ns/10ps
module dfl_history #(
  parameter int unsigned DEPTH = dfl_pkg::HIST_DEPTH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic push_i,
  input wire dfl_pkg::dfl_entry_type entry_i,
  input wire logic step_i,
  output dfl_pkg::dfl_entry_type view_o,
  output logic [1:0] view_idx_o
);
  dfl_pkg::dfl_entry_type hist_reg [DEPTH];
  logic [1:0] idx_reg;

  // (RL15) three entries kept
  // (RL19) shift back, oldest dropped
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_hist
    if (g == 0) begin : g_head
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          hist_reg[g] <= '0;
        end else if (push_i) begin
          hist_reg[g] <= entry_i;
        end
      end
    end else begin : g_tail
      // Elaborated only where a newer neighbour exists
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          hist_reg[g] <= '0;
        end else if (push_i) begin
          hist_reg[g] <= hist_reg[g-1];
        end
      end
    end
  end

  // (RL16) shift key steps view
  always_ff @(posedge clk_i) begin
    if (reset_i || push_i) begin
      idx_reg <= 2'h0; // New trip shows the most recent first
    end else if (step_i) begin
      if (idx_reg == 2'(DEPTH - 1)) begin
        idx_reg <= 2'h0;
      end else begin
        idx_reg <= idx_reg + 2'h1;
      end
    end
  end

  // Registered view so the display data is glitch free
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      view_o <= '0;
    end else begin
      view_o <= hist_reg[idx_reg];
    end
  end

  assign view_idx_o = idx_reg;

  a_view_wraps: assert property (@(posedge clk_i) disable iff (reset_i)
    (step_i && !push_i && idx_reg == 2'h2) |=> idx_reg == 2'h0) // RL16
    else $error("history view did not wrap");
  a_hist_shift: assert property (@(posedge clk_i) disable iff (reset_i)
    push_i |=> hist_reg[1] == $past(hist_reg[0])) // RL19
    else $error("history did not shift");
  a_hist_new: assert property (@(posedge clk_i) disable iff (reset_i)
    push_i |=> hist_reg[0] == $past(entry_i)) // RL15
    else $error("newest entry not stored");
endmodule

// ---- sim/dfl_panel_model.sv ----
// Detector, keypad and terminal model facing the fault latch
`timescale 1ns/10ps
module dfl_panel_model (
  input wire logic clk_i,
  output dfl_pkg::dfl_det_type det_o,
  output dfl_pkg::dfl_phase_type phase_o,
  output dfl_pkg::dfl_cond_type cond_o,
  output logic thermal_o,
  output logic term_o,
  output logic key_o,
  output logic shift_o,
  output logic restart_o,
  output logic link_o
);
  // Idle state: no faults, thermal contact closed
  initial begin
    det_o = '0;
    phase_o = dfl_pkg::DFL_PH_STEADY;
    cond_o = '0;
    thermal_o = 1'h1;
    term_o = 1'h0;
    key_o = 1'h0;
    shift_o = 1'h0;
    restart_o = 1'h0;
    link_o = 1'h0;
  end

  // Detectors and monitors move together so a trip captures one set
  task automatic drive(input dfl_pkg::dfl_det_type d,
      input dfl_pkg::dfl_phase_type ph, input dfl_pkg::dfl_cond_type c,
      input logic th);
    @(posedge clk_i);
    det_o <= d;
    phase_o <= ph;
    cond_o <= c;
    thermal_o <= th;
    @(negedge clk_i);
  endtask

  // Mode selections from the terminal block
  task automatic modes(input logic rs, input logic lk);
    @(posedge clk_i);
    restart_o <= rs;
    link_o <= lk;
    @(negedge clk_i);
  endtask

  // operator reset key, reset terminal or shift key press
  // Held past the synchronizer so one press gives exactly one edge
  task automatic press(input int unsigned which);
    @(posedge clk_i);
    key_o <= (which == 0);
    term_o <= (which == 1);
    shift_o <= (which == 2);
    repeat (4) @(posedge clk_i);
    key_o <= 1'h0;
    term_o <= 1'h0;
    shift_o <= 1'h0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the fault latch and trip history
`timescale 1ns/10ps
module tb;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  dfl_pkg::dfl_det_type det;
  dfl_pkg::dfl_phase_type phase;
  dfl_pkg::dfl_cond_type cond;
  logic thermal, term, key, shift, restart, link;
  logic drive_en, coast, alarm;
  dfl_pkg::dfl_code_type code;
  dfl_pkg::dfl_entry_type view;
  logic [1:0] idx;
  int fails = 0;
  int total_checks = 0;
  logic [15:0] n = 16'h1000;
  dfl_pkg::dfl_entry_type hist_q[$];

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  dfl_panel_model pm_u (.clk_i(clk_i), .det_o(det), .phase_o(phase),
    .cond_o(cond), .thermal_o(thermal), .term_o(term), .key_o(key),
    .shift_o(shift), .restart_o(restart), .link_o(link));

  // Short dip limit keeps the long-dip cases brief
  dfl_fault_latch #(.DIP_LIMIT_CYC(20)) dut_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .det_i(det),
    .phase_i(phase),
    .cond_i(cond),
    .external_thermal_input_i(thermal),
    .fault_reset_input_i(term),
    .reset_key_i(key),
    .shift_key_i(shift),
    .restart_mode_i(restart),
    .link_mode_i(link),
    .drive_enable_o(drive_en),
    .coast_o(coast),
    .alarm_o(alarm),
    .code_o(code),
    .hist_view_o(view),
    .hist_idx_o(idx)
  );

  // Report counts and verdict, then stop
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [67:0] got, input logic [67:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait on alarm (sel 0) or drive enable (sel 1)
  task automatic wait_out(input int unsigned sel, input logic v);
    int k;
    k = 0;
    while ((sel == 0 ? alarm : drive_en) !== v && k < 40) begin
      @(negedge clk_i);
      k++;
    end
    if ((sel == 0 ? alarm : drive_en) !== v) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time,
        (sel == 0 ? alarm : drive_en), v);
      conclude();
    end
  endtask

  // One trip: classify, stop, latch, log, then clear by reset source rk
  task automatic do_trip(input dfl_pkg::dfl_det_type d,
      input dfl_pkg::dfl_phase_type ph, input logic th,
      input logic [3:0] c, input int unsigned rk);
    dfl_pkg::dfl_cond_type cv;
    cv = {n, n + 16'h0001, n + 16'h0002, n + 16'h0003};
    n = n + 16'h0010;
    pm_u.drive(d, ph, cv, th);
    wait_out(0, 1'h1);
    chk(code, c);
    chk(drive_en, 1'h0);
    chk(coast, 1'h1);
    hist_q.push_back({c, cv});
    pm_u.drive('0, ph, cv, 1'h1);
    repeat (10) @(negedge clk_i);
    chk(alarm, 1'h1);
    chk(view, {c, cv});
    pm_u.press(rk);
    wait_out(0, 1'h0);
    chk(code, 4'h0);
    chk(drive_en, 1'h1);
    chk(view, {c, cv});
  endtask

  // Shift key walks newest, second, third, then wraps
  task automatic check_hist();
    chk(idx, 2'h0);
    chk(view, hist_q[$]);
    pm_u.press(2);
    chk(idx, 2'h1);
    chk(view, hist_q[$-1]);
    pm_u.press(2);
    chk(idx, 2'h2);
    chk(view, hist_q[$-2]);
    pm_u.press(2);
    chk(idx, 2'h0);
  endtask

  // Dips: short ride-through, long stop with and without restart
  task automatic dip_test();
    dfl_pkg::dfl_det_type d;
    d = '0;
    d.undervoltage = 1'h1;
    pm_u.drive(d, dfl_pkg::DFL_PH_STEADY, '0, 1'h1);
    repeat (12) begin
      chk(drive_en, 1'h1);
      @(negedge clk_i);
    end
    pm_u.drive('0, dfl_pkg::DFL_PH_STEADY, '0, 1'h1);
    repeat (6) begin
      chk(drive_en, 1'h1);
      @(negedge clk_i);
    end
    pm_u.modes(1'h1, 1'h0);
    pm_u.drive(d, dfl_pkg::DFL_PH_STEADY, '0, 1'h1);
    repeat (40) @(negedge clk_i);
    chk(code, 4'h4);
    chk(drive_en, 1'h0);
    chk(alarm, 1'h0);
    pm_u.drive('0, dfl_pkg::DFL_PH_STEADY, '0, 1'h1);
    wait_out(1, 1'h1);
    pm_u.modes(1'h0, 1'h0);
    pm_u.drive(d, dfl_pkg::DFL_PH_STEADY, '0, 1'h1);
    repeat (40) @(negedge clk_i);
    chk(code, 4'h4);
    pm_u.drive('0, dfl_pkg::DFL_PH_STEADY, '0, 1'h1);
    repeat (30) @(negedge clk_i);
    chk(drive_en, 1'h0);
    pm_u.press(0);
    wait_out(1, 1'h1);
    chk(code, 4'h0);
  endtask

  // Main sequence
  initial begin
    dfl_pkg::dfl_det_type d;
    int unsigned bit_pos[7] = '{7, 6, 5, 3, 2, 1, 0};
    logic [3:0] exp_code[7] = '{4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
    repeat (5) @(posedge clk_i);
    reset_i <= 1'h0;
    @(negedge clk_i);
    chk(drive_en, 1'h1);
    chk(alarm, 1'h0);
    chk(code, 4'h0);
    d = '0;
    d.overcurrent = 1'h1;
    do_trip(d, dfl_pkg::DFL_PH_ACCEL, 1'h1, 4'h1, 0);
    do_trip(d, dfl_pkg::DFL_PH_DECEL, 1'h1, 4'h2, 1);
    do_trip(d, dfl_pkg::DFL_PH_STEADY, 1'h1, 4'h3, 0);
    check_hist();
    // Other causes one at a time, link operation active
    pm_u.modes(1'h0, 1'h1);
    for (int i = 0; i < 7; i++) begin
      d = dfl_pkg::dfl_det_type'(9'h001 << bit_pos[i]);
      do_trip(d, dfl_pkg::DFL_PH_STEADY, 1'h1, exp_code[i], i % 2);
    end
    do_trip('0, dfl_pkg::DFL_PH_ACCEL, 1'h0, 4'h7, 1);
    check_hist();
    dip_test();
    // Link mismatch is ignored while link operation is off
    d = '0;
    d.link_mismatch = 1'h1;
    pm_u.drive(d, dfl_pkg::DFL_PH_STEADY, '0, 1'h1);
    repeat (10) @(negedge clk_i);
    chk(alarm, 1'h0);
    chk(drive_en, 1'h1);
    pm_u.drive('0, dfl_pkg::DFL_PH_STEADY, '0, 1'h1);
    conclude();
  end
endmodule
